// >>> smpa_pkg.sv
// Package: offsets, field positions, reset values and timing for the event aggregator
package smpa_pkg;

	// ------------------------------------------------------------
	// Runtime register offsets from the block base
	// ------------------------------------------------------------
	localparam logic [7:0] SMPA_OFF_WAKE_STS    = 8'h00; // summary status, global enable
	localparam logic [7:0] SMPA_OFF_WAKE_STS3   = 8'h04; // wake status three
	localparam logic [7:0] SMPA_OFF_WAKE_STS4   = 8'h05; // gpio/tach wake status
	localparam logic [7:0] SMPA_OFF_WAKE_EN3    = 8'h08; // wake enable three
	localparam logic [7:0] SMPA_OFF_WAKE_EN4    = 8'h09; // gpio/tach wake enable
	localparam logic [7:0] SMPA_OFF_MGMT_STS1   = 8'h14; // unit events, low byte
	localparam logic [7:0] SMPA_OFF_MGMT_STS2   = 8'h15; // unit events, high byte
	localparam logic [7:0] SMPA_OFF_MGMT_STS3   = 8'h16; // gpio/tach latched status
	localparam logic [7:0] SMPA_OFF_MGMT_EN1    = 8'h17;
	localparam logic [7:0] SMPA_OFF_MGMT_EN2    = 8'h18;
	localparam logic [7:0] SMPA_OFF_MGMT_EN3    = 8'h19;
	localparam logic [7:0] SMPA_OFF_MGMT_PIN    = 8'h20; // mgmt_pin_control
	localparam logic [7:0] SMPA_OFF_WAKE_PIN    = 8'h21; // wake_pin_control
	localparam logic [7:0] SMPA_OFF_EDGE_CFG    = 8'h22; // per-input polarity
	localparam logic [7:0] SMPA_OFF_EITHER_EDGE_TRIGGER_CFG    = 8'h23; // per-input either-edge select
	localparam logic [7:0] SMPA_OFF_LAMP_ONE    = 8'h5d;
	localparam logic [7:0] SMPA_OFF_LAMP_TWO    = 8'h5e;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SMPA_BIT_BUF_PUSHPULL = 7; // pin control: 1 = push-pull
	localparam int SMPA_BIT_POL_INVERT   = 0; // pin control: 1 = active high
	localparam int SMPA_BIT_PIN_IRQ  = 7; // mgmt_enable_two: to pin
	localparam int SMPA_BIT_SERIRQ   = 6; // mgmt_enable_two: to IRQ2 slot
	localparam int SMPA_BIT_TO_WAKE  = 5; // mgmt_enable_two: into wake logic
	localparam int SMPA_BIT_IR_EVT   = 6; // infrared bit in mgmt_status_two
	localparam int SMPA_BIT_ROUTED   = 3; // routed_irq_wake_status/enable
	localparam int SMPA_BIT_GLB_EN   = 1; // wake_global_enable
	localparam int SMPA_BIT_SUMMARY  = 0; // wake_summary_status

	// Wake status three sources
	localparam int SMPA_W3_RING_ONE = 0;
	localparam int SMPA_W3_RING_TWO = 1;
	localparam int SMPA_W3_IR_FRAME = 2;
	localparam int SMPA_W3_KBD      = 4;
	localparam int SMPA_W3_MOUSE    = 5;

	// ------------------------------------------------------------
	// Reset values and lamp encoding
	// ------------------------------------------------------------
	localparam logic [7:0] SMPA_RST_PIN_CTRL = 8'h00; // active low, open drain
	localparam logic [7:0] SMPA_RST_REG      = 8'h00;
	localparam logic [1:0] SMPA_LAMP_OFF     = 2'h0;
	localparam logic [1:0] SMPA_LAMP_BLINK   = 2'h1;
	localparam logic [1:0] SMPA_LAMP_ON      = 2'h2;
	localparam int SMPA_BLINK_DIV_W = 15; // 32768 Hz / 2^15 = 1 s period

	// Number of gpio/tach edge inputs
	localparam int SMPA_NUM_EDGE = 8;

endpackage : smpa_pkg

// >>> smpa_regbus_if.sv
// Interface: internal register strobe bundle between the top and the edge latch
`timescale 1ns/1ps
interface smpa_regbus_if;
	import smpa_pkg::*;
	logic [SMPA_NUM_EDGE-1:0] clr_mask;  // write-one-to-clear pulse
	logic [SMPA_NUM_EDGE-1:0] pol_inv;   // 1 = falling edge
	logic [SMPA_NUM_EDGE-1:0] both_edge; // either_edge_trigger
	logic [SMPA_NUM_EDGE-1:0] status;    // latched status
	modport host (output clr_mask, output pol_inv, output both_edge, input status);
	modport latch (input clr_mask, input pol_inv, input both_edge, output status);
endinterface : smpa_regbus_if

// >>> smpa_edge_latch.sv
// Edge-detecting sticky status bits with write-one-to-clear
`timescale 1ns/1ps
module smpa_edge_latch
	import smpa_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire logic [SMPA_NUM_EDGE-1:0] edge_in,
	smpa_regbus_if.latch                  bus
);
	logic [SMPA_NUM_EDGE-1:0] prev_q;
	logic [SMPA_NUM_EDGE-1:0] sts_q;
	logic [SMPA_NUM_EDGE-1:0] hit;

	// ------------------------------------------------------------
	// Per-bit edge select
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < SMPA_NUM_EDGE; i++) begin : g_bit
			wire rise = edge_in[i] & ~prev_q[i];
			wire fall = ~edge_in[i] & prev_q[i];
			// Polarity chooses edge; either-edge overrides polarity
			assign hit[i] = bus.both_edge[i] ? (rise | fall) :
				(bus.pol_inv[i] ? fall : rise); // see [RULE7] see [RULE17]
		end
	endgenerate

	// Set wins over a simultaneous clear so no edge is lost
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= '0;
			sts_q  <= '0;
		end else begin
			prev_q <= edge_in;
			sts_q  <= hit | (sts_q & ~bus.clr_mask); // see [RULE8]
		end
	end

	assign bus.status = sts_q;

endmodule : smpa_edge_latch

// >>> smpa_lamp_drv.sv
// Lamp driver: off, on or blink from the standby clock
`timescale 1ns/1ps
module smpa_lamp_drv
	import smpa_pkg::*;
(
	input  wire logic       clk_32k,
	input  wire logic       rst_b,
	input  wire logic [1:0] mode,
	output logic            lamp_on
);
	logic [SMPA_BLINK_DIV_W-1:0] div_q;
	logic [1:0]                  mode_s1_q;
	logic [1:0]                  mode_s2_q;

	// Free-running divider; standby clock is always present
	// Mode comes from ref_clk: two flops; a two-bit change may show one stray cycle
	always_ff @(posedge clk_32k or negedge rst_b) begin
		if (!rst_b) begin
			div_q     <= '0;
			mode_s1_q <= SMPA_LAMP_OFF;
			mode_s2_q <= SMPA_LAMP_OFF;
			lamp_on   <= 1'b0;
		end else begin
			div_q     <= div_q + 1'b1;
			mode_s1_q <= mode;
			mode_s2_q <= mode_s1_q;
			lamp_on   <= (mode_s2_q == SMPA_LAMP_ON) ||
				((mode_s2_q == SMPA_LAMP_BLINK) && div_q[SMPA_BLINK_DIV_W-1]); // see [RULE21]
		end
	end

endmodule : smpa_lamp_drv

// >>> smpa_event_agg.sv
// Top: management-interrupt and wake-event aggregation, pin drivers and lamps
`timescale 1ns/1ps

// Operation
// [RULE1] Management pin active level follows its polarity bit, default active low.
// [RULE2] Management pin control bit 7 picks push-pull, else open-drain (default).
// [RULE3] Group interrupt is OR of all enabled events over five enable groups; the code ORs over three enable registers (en1, en2, en3).
// [RULE4] Group interrupt reaches its pin only while mgmt_enable_two bit 7 set.
// [RULE5] mgmt_enable_two bit 6 places group interrupt in serial IRQ2 slot.
// [RULE6] mgmt_enable_two bit 5 feeds group interrupt into wake logic.
// [RULE7] GPIO/tach status sets on polarity-selected edge, or both for either-edge pins.
// [RULE8] GPIO/tach status clears only on a written one.
// [RULE9] Latched GPIO/tach status ANDed with enable forms its interrupt.
// [RULE10] Unit status bits follow sources; infrared clears on reading status two.
// [RULE11] Unit event signals ANDed unlatched with enables.
// [RULE12] Global wake enable clear blocks the wake output entirely.
// [RULE13] Wake status bits set on active transitions regardless of global enable.
// [RULE14] Wake sources: rings, infrared frames, keyboard, mouse, GPIO, tachometers.
// [RULE15] Summary wake status holds until all enabled pending bits clear.
// [RULE16] Wake pin follows polarity bit and bit 7 buffer type, default low open-drain.
// [RULE17] GPIO wake status set on selected edge(s), cleared by writing one.
// [RULE18] Routed status bit 3 sets while group interrupt active and routed.
// [RULE19] Routed enable and status both set drive the wake pin active.
// [RULE20] Two lamps switch on, off or blink via registers at 0x5d, 0x5e.
// [RULE21] Lamps blink from the 32 kHz standby clock on either buffer type.
// [RULE22] Lamp field encoding and blink period chosen locally.
module smpa_event_agg
	import smpa_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire logic                     clk_32k,
	input  wire logic                     io_rd,
	input  wire logic                     io_wr,
	input  wire logic [7:0]               io_addr,
	input  wire logic [7:0]               io_wdata,
	output logic      [7:0]               io_rdata,
	input  wire logic [15:0]              unit_events,
	input  wire logic                     infrared_irq_event,
	input  wire logic [SMPA_NUM_EDGE-1:0] gpio_tach_in,
	input  wire logic                     ring_indicator_one_b,
	input  wire logic                     ring_indicator_two_b,
	input  wire logic                     ir_frame_valid,
	input  wire logic                     kbd_data_edge,
	input  wire logic                     mouse_data_edge,
	output logic                          group_mgmt_irq,
	output logic                          serirq_slot2,
	output logic                          mgmt_irq_pin_o,
	output logic                          mgmt_irq_pin_oe,
	output logic                          wake_event_pin_o,
	output logic                          wake_event_pin_oe,
	output logic                          lamp_pin_one_o,
	output logic                          lamp_pin_one_oe,
	output logic                          lamp_pin_two_o,
	output logic                          lamp_pin_two_oe
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] mgmt_en1_q;
	logic [7:0] mgmt_enable_two_q;
	logic [7:0] mgmt_en3_q;
	logic [7:0] mgmt_pin_control_q;
	logic [7:0] wake_pin_control_q;
	logic [7:0] edge_pol_q;
	logic [7:0] either_edge_trigger_q;
	logic [7:0] wake_enable_three_q;
	logic [7:0] wake_en4_q;
	logic [7:0] wake_status_three_q;
	logic       wake_global_enable_q;
	logic       ir_latch_q;
	logic [7:0] lamp_one_control_q;
	logic [7:0] lamp_two_control_q;
	logic [7:0] io_rdata_q;
	logic [4:0] w3_prev_q;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire wr_wake_sts  = io_wr && (io_addr == SMPA_OFF_WAKE_STS);
	wire wr_w3        = io_wr && (io_addr == SMPA_OFF_WAKE_STS3);
	wire wr_w4        = io_wr && (io_addr == SMPA_OFF_WAKE_STS4);
	wire wr_m3        = io_wr && (io_addr == SMPA_OFF_MGMT_STS3);
	wire wr_wen3      = io_wr && (io_addr == SMPA_OFF_WAKE_EN3);
	wire wr_wen4      = io_wr && (io_addr == SMPA_OFF_WAKE_EN4);
	wire wr_men1      = io_wr && (io_addr == SMPA_OFF_MGMT_EN1);
	wire wr_men2      = io_wr && (io_addr == SMPA_OFF_MGMT_EN2);
	wire wr_men3      = io_wr && (io_addr == SMPA_OFF_MGMT_EN3);
	wire wr_mpin      = io_wr && (io_addr == SMPA_OFF_MGMT_PIN);
	wire wr_wpin      = io_wr && (io_addr == SMPA_OFF_WAKE_PIN);
	wire wr_pol       = io_wr && (io_addr == SMPA_OFF_EDGE_CFG);
	wire wr_either_edge_trigger      = io_wr && (io_addr == SMPA_OFF_EITHER_EDGE_TRIGGER_CFG);
	wire wr_lamp1     = io_wr && (io_addr == SMPA_OFF_LAMP_ONE);
	wire wr_lamp2     = io_wr && (io_addr == SMPA_OFF_LAMP_TWO);
	wire rd_ms2       = io_rd && (io_addr == SMPA_OFF_MGMT_STS2);

	// ------------------------------------------------------------
	// Two latch instances share the gpio inputs: one for the
	// management side, one for wake; each clears independently
	// ------------------------------------------------------------
	smpa_regbus_if m_bus ();
	smpa_regbus_if w_bus ();

	assign m_bus.clr_mask  = wr_m3 ? io_wdata : 8'h00; // see [RULE8]
	assign m_bus.pol_inv   = edge_pol_q;
	assign m_bus.both_edge = either_edge_trigger_q;
	assign w_bus.clr_mask  = wr_w4 ? io_wdata : 8'h00; // see [RULE17]
	assign w_bus.pol_inv   = edge_pol_q;
	assign w_bus.both_edge = either_edge_trigger_q;

	smpa_edge_latch u_mgmt_latch (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.edge_in (gpio_tach_in),
		.bus     (m_bus)
	);

	smpa_edge_latch u_wake_latch (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.edge_in (gpio_tach_in),
		.bus     (w_bus)
	);

	// ------------------------------------------------------------
	// Group management interrupt
	// ------------------------------------------------------------
	// Unit events are level signals, combined without latching
	wire [15:0] unit_src  = {unit_events[15], ir_latch_q, unit_events[13:0]};
	wire [15:0] unit_hits = unit_src & {mgmt_enable_two_q & 8'h1f, mgmt_en1_q}; // see [RULE11]
	wire [7:0]  gpio_hits = m_bus.status & mgmt_en3_q;                           // see [RULE9]
	assign group_mgmt_irq = (|unit_hits) | (|gpio_hits);                         // see [RULE3]

	// Routing enables from mgmt_enable_two
	wire to_pin  = mgmt_enable_two_q[SMPA_BIT_PIN_IRQ];  // see [RULE4]
	wire to_ser  = mgmt_enable_two_q[SMPA_BIT_SERIRQ];   // see [RULE5]
	wire to_wake = mgmt_enable_two_q[SMPA_BIT_TO_WAKE];  // see [RULE6]
	assign serirq_slot2 = group_mgmt_irq & to_ser;       // see [RULE5]
	wire mgmt_active = group_mgmt_irq & to_pin;          // see [RULE4]

	// ------------------------------------------------------------
	// Pin drivers: open-drain drives only while the pin level is low
	// ------------------------------------------------------------
	wire mpol = mgmt_pin_control_q[SMPA_BIT_POL_INVERT];
	wire mpp  = mgmt_pin_control_q[SMPA_BIT_BUF_PUSHPULL];
	wire mlvl = mpol ? mgmt_active : ~mgmt_active;      // see [RULE1]
	assign mgmt_irq_pin_o  = mlvl;
	assign mgmt_irq_pin_oe = mpp | (mlvl == 1'b0);      // see [RULE2]

	// ------------------------------------------------------------
	// Wake sources: active transitions of rings (low-going) and
	// pulses from frame, keyboard and mouse detectors
	// ------------------------------------------------------------
	wire [4:0] w3_now  = {mouse_data_edge, kbd_data_edge, ir_frame_valid,
		~ring_indicator_two_b, ~ring_indicator_one_b};
	wire [4:0] w3_rise = w3_now & ~w3_prev_q;           // see [RULE14]
	wire [7:0] w3_set;
	assign w3_set[SMPA_W3_RING_ONE] = w3_rise[0];
	assign w3_set[SMPA_W3_RING_TWO] = w3_rise[1];
	assign w3_set[SMPA_W3_IR_FRAME] = w3_rise[2];
	assign w3_set[SMPA_BIT_ROUTED]  = group_mgmt_irq & to_wake; // see [RULE18]
	assign w3_set[SMPA_W3_KBD]      = w3_rise[3];
	assign w3_set[SMPA_W3_MOUSE]    = w3_rise[4];
	assign w3_set[7:6]              = 2'h0;

	// Pending enabled bits; the summary tracks these directly
	wire w3_pend  = |(wake_status_three_q & wake_enable_three_q); // see [RULE19]
	wire w4_pend  = |(w_bus.status & wake_en4_q);
	wire wake_summary_status = w3_pend | w4_pend;                 // see [RULE15]
	wire wake_active = wake_global_enable_q & wake_summary_status; // see [RULE12]

	wire wpol = wake_pin_control_q[SMPA_BIT_POL_INVERT];
	wire wpp  = wake_pin_control_q[SMPA_BIT_BUF_PUSHPULL];
	wire wlvl = wpol ? wake_active : ~wake_active;                // see [RULE16]
	assign wake_event_pin_o  = wlvl;
	assign wake_event_pin_oe = wpp | (wlvl == 1'b0);              // see [RULE16]

	// ------------------------------------------------------------
	// Control register writes
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mgmt_en1_q          <= SMPA_RST_REG;
			mgmt_enable_two_q   <= SMPA_RST_REG;
			mgmt_en3_q          <= SMPA_RST_REG;
			mgmt_pin_control_q  <= SMPA_RST_PIN_CTRL;
			wake_pin_control_q  <= SMPA_RST_PIN_CTRL;
			edge_pol_q          <= SMPA_RST_REG;
			either_edge_trigger_q              <= SMPA_RST_REG;
			wake_enable_three_q <= SMPA_RST_REG;
			wake_en4_q          <= SMPA_RST_REG;
			lamp_one_control_q  <= SMPA_RST_REG;
			lamp_two_control_q  <= SMPA_RST_REG;
			wake_global_enable_q <= 1'b0;
		end else begin
			if (wr_men1)  mgmt_en1_q          <= io_wdata;
			if (wr_men2)  mgmt_enable_two_q   <= io_wdata;
			if (wr_men3)  mgmt_en3_q          <= io_wdata;
			if (wr_mpin)  mgmt_pin_control_q  <= io_wdata;
			if (wr_wpin)  wake_pin_control_q  <= io_wdata;
			if (wr_pol)   edge_pol_q          <= io_wdata;
			if (wr_either_edge_trigger)  either_edge_trigger_q              <= io_wdata;
			if (wr_wen3)  wake_enable_three_q <= io_wdata;
			if (wr_wen4)  wake_en4_q          <= io_wdata;
			if (wr_lamp1) lamp_one_control_q  <= io_wdata; // see [RULE20]
			if (wr_lamp2) lamp_two_control_q  <= io_wdata; // see [RULE20]
			if (wr_wake_sts) wake_global_enable_q <= io_wdata[SMPA_BIT_GLB_EN];
		end
	end

	// ------------------------------------------------------------
	// Sticky status: set wins over write-one clear
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_status_three_q <= SMPA_RST_REG;
			w3_prev_q           <= 5'h00;
			ir_latch_q          <= 1'b0;
		end else begin
			w3_prev_q <= w3_now;
			// Set regardless of global enable
			wake_status_three_q <= w3_set |
				(wake_status_three_q & ~(wr_w3 ? io_wdata : 8'h00)); // see [RULE13]
			// Infrared held until status two is read; new event wins
			ir_latch_q <= infrared_irq_event | (ir_latch_q & ~rd_ms2); // see [RULE10]
		end
	end

	// ------------------------------------------------------------
	// Read mux, registered one cycle after io_rd
	// ------------------------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		unique case (io_addr)
			SMPA_OFF_WAKE_STS:  rd_mux = {6'h00, wake_global_enable_q, wake_summary_status};
			SMPA_OFF_WAKE_STS3: rd_mux = wake_status_three_q;
			SMPA_OFF_WAKE_STS4: rd_mux = w_bus.status;
			SMPA_OFF_WAKE_EN3:  rd_mux = wake_enable_three_q;
			SMPA_OFF_WAKE_EN4:  rd_mux = wake_en4_q;
			SMPA_OFF_MGMT_STS1: rd_mux = unit_src[7:0];   // see [RULE10]
			SMPA_OFF_MGMT_STS2: rd_mux = unit_src[15:8];
			SMPA_OFF_MGMT_STS3: rd_mux = m_bus.status;
			SMPA_OFF_MGMT_EN1:  rd_mux = mgmt_en1_q;
			SMPA_OFF_MGMT_EN2:  rd_mux = mgmt_enable_two_q;
			SMPA_OFF_MGMT_EN3:  rd_mux = mgmt_en3_q;
			SMPA_OFF_MGMT_PIN:  rd_mux = mgmt_pin_control_q;
			SMPA_OFF_WAKE_PIN:  rd_mux = wake_pin_control_q;
			SMPA_OFF_EDGE_CFG:  rd_mux = edge_pol_q;
			SMPA_OFF_EITHER_EDGE_TRIGGER_CFG:  rd_mux = either_edge_trigger_q;
			SMPA_OFF_LAMP_ONE:  rd_mux = lamp_one_control_q;
			SMPA_OFF_LAMP_TWO:  rd_mux = lamp_two_control_q;
			default:            rd_mux = 8'h00; // unmapped reads zero
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) io_rdata_q <= 8'h00;
		else if (io_rd) io_rdata_q <= rd_mux;
	end
	assign io_rdata = io_rdata_q;

	// ------------------------------------------------------------
	// Lamps: bit 7 of each lamp register picks push-pull;
	// open-drain sinks (drives low) while lit
	// ------------------------------------------------------------
	logic lamp1_lit;
	logic lamp2_lit;
	smpa_lamp_drv u_lamp1 (
		.clk_32k (clk_32k),
		.rst_b   (rst_b),
		.mode    (lamp_one_control_q[1:0]), // see [RULE22]
		.lamp_on (lamp1_lit)
	);
	smpa_lamp_drv u_lamp2 (
		.clk_32k (clk_32k),
		.rst_b   (rst_b),
		.mode    (lamp_two_control_q[1:0]), // see [RULE22]
		.lamp_on (lamp2_lit)
	);
	// Push-pull sources current when lit; open-drain sinks
	assign lamp_pin_one_o  = lamp_one_control_q[SMPA_BIT_BUF_PUSHPULL] ? lamp1_lit : 1'b0;
	assign lamp_pin_one_oe = lamp_one_control_q[SMPA_BIT_BUF_PUSHPULL] | lamp1_lit; // see [RULE21]
	assign lamp_pin_two_o  = lamp_two_control_q[SMPA_BIT_BUF_PUSHPULL] ? lamp2_lit : 1'b0;
	assign lamp_pin_two_oe = lamp_two_control_q[SMPA_BIT_BUF_PUSHPULL] | lamp2_lit; // see [RULE21]

endmodule : smpa_event_agg

// >>> smpa_event_agg_monitor.sv
// Checker: port-level assertions for the event aggregator
`timescale 1ns/1ps
module smpa_event_agg_monitor
	import smpa_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        io_wr,
	input wire logic [7:0]  io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic [15:0] unit_events,
	input wire logic        group_mgmt_irq,
	input wire logic        serirq_slot2,
	input wire logic        mgmt_irq_pin_o,
	input wire logic        mgmt_irq_pin_oe,
	input wire logic        wake_event_pin_o,
	input wire logic        wake_event_pin_oe
);
	// ------------------------------------------------------------
	// Shadow copies of the routing registers
	// ------------------------------------------------------------
	logic [7:0] en1_q, en2_q, en3_q, mpin_q, wpin_q, glb_q;

	// Tracks host writes; updates on the same edge as the block
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{en1_q, en2_q, en3_q, mpin_q, wpin_q, glb_q} <= '0;
		end else if (io_wr) begin
			case (io_addr)
				SMPA_OFF_MGMT_EN1: en1_q <= io_wdata;
				SMPA_OFF_MGMT_EN2: en2_q <= io_wdata;
				SMPA_OFF_MGMT_EN3: en3_q <= io_wdata;
				SMPA_OFF_MGMT_PIN: mpin_q <= io_wdata;
				SMPA_OFF_WAKE_PIN: wpin_q <= io_wdata;
				SMPA_OFF_WAKE_STS: glb_q <= io_wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	chk_pin_level: assert property (
		mgmt_irq_pin_o == ((group_mgmt_irq && en2_q[7]) ? mpin_q[0] : !mpin_q[0]))
		else $error("management pin level wrong");
	chk_pin_pushpull: assert property (mpin_q[7] |-> mgmt_irq_pin_oe)
		else $error("management pin not driven in push-pull");
	chk_pin_opendrain: assert property (
		!mpin_q[7] && !mpin_q[0] |-> mgmt_irq_pin_oe == (group_mgmt_irq && en2_q[7]))
		else $error("management pin open-drain drive wrong");
	chk_serirq_route: assert property (
		serirq_slot2 == (group_mgmt_irq && en2_q[6]))
		else $error("slot two routing wrong");
	chk_unit_direct: assert property (
		unit_events[0] && en1_q[0] |-> group_mgmt_irq)
		else $error("enabled unit event missing from group");
	chk_group_quiet: assert property (
		en1_q == 8'h00 && en2_q == 8'h00 && en3_q == 8'h00 |-> !group_mgmt_irq)
		else $error("group active with nothing enabled");
	chk_wake_blocked: assert property (
		!glb_q[1] |-> wake_event_pin_o == !wpin_q[0])
		else $error("wake pin active while globally disabled");
	chk_wake_pushpull: assert property (wpin_q[7] |-> wake_event_pin_oe)
		else $error("wake pin not driven in push-pull");
endmodule : smpa_event_agg_monitor

bind smpa_event_agg smpa_event_agg_monitor smpa_event_agg_monitor_inst (.ref_clk, .rst_b,
	.io_wr, .io_addr, .io_wdata, .unit_events, .group_mgmt_irq, .serirq_slot2,
	.mgmt_irq_pin_o, .mgmt_irq_pin_oe, .wake_event_pin_o, .wake_event_pin_oe);

// >>> smpa_host_model.sv
// Host chipset side: pulled-up management and wake lines
`timescale 1ns/1ps
module smpa_host_model (
	input  wire logic mgmt_o,
	input  wire logic mgmt_oe,
	input  wire logic wake_o,
	input  wire logic wake_oe,
	output logic      mgmt_line,
	output logic      wake_line
);
	// Board pull-ups; a released open-drain line floats high
	assign mgmt_line = mgmt_oe ? mgmt_o : 1'b1;
	assign wake_line = wake_oe ? wake_o : 1'b1;
endmodule : smpa_host_model

// >>> smpa_event_agg_tb.sv
// Testbench: register-level sequences for the event aggregator
`timescale 1ns/1ps
module smpa_event_agg_tb;
	import smpa_pkg::*;
	logic ref_clk, rst_b, clk_32k, io_rd, io_wr, ir_evt, irq, ser, m_line, w_line;
	logic m_o, m_oe, w_o, w_oe, l1_o, l1_oe, l2_o, l2_oe;
	logic [7:0] io_addr, io_wdata, io_rdata, rd_v, gpio_tach_in;
	logic [15:0] unit_events;
	logic [4:0] src;
	int failures, cmp_count;

	smpa_event_agg smpa_event_agg_inst (.ref_clk, .rst_b, .clk_32k, .io_rd, .io_wr, .io_addr,
		.io_wdata, .io_rdata, .unit_events, .infrared_irq_event(ir_evt), .gpio_tach_in,
		.ring_indicator_one_b(~src[0]), .ring_indicator_two_b(~src[1]),
		.ir_frame_valid(src[2]), .kbd_data_edge(src[3]), .mouse_data_edge(src[4]),
		.group_mgmt_irq(irq), .serirq_slot2(ser), .mgmt_irq_pin_o(m_o),
		.mgmt_irq_pin_oe(m_oe), .wake_event_pin_o(w_o), .wake_event_pin_oe(w_oe),
		.lamp_pin_one_o(l1_o), .lamp_pin_one_oe(l1_oe), .lamp_pin_two_o(l2_o),
		.lamp_pin_two_oe(l2_oe));
	smpa_host_model smpa_host_model_inst (.mgmt_o(m_o), .mgmt_oe(m_oe), .wake_o(w_o),
		.wake_oe(w_oe), .mgmt_line(m_line), .wake_line(w_line));

	// Clocks: standby clock free-running, unrelated phase
	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		clk_32k = 0;
		#3;
		forever #15259 clk_32k = ~clk_32k;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 io_wr = 1; io_addr = a; io_wdata = d;
		@(posedge ref_clk);
		#1 io_wr = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		#1 io_rd = 1; io_addr = a;
		@(posedge ref_clk);
		#1 io_rd = 0; rd_v = io_rdata;
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	// Watchdog well beyond the expected run of about 12k cycles
	initial begin
		#2000000;
		failures++;
		give_verdict;
	end

	// Main sequence
	initial begin
		{io_rd, io_wr, io_addr, io_wdata, unit_events, gpio_tach_in, src, ir_evt} = '0;
		rst_b = 0;
		repeat (10) @(posedge ref_clk);
		#1 rst_b = 1;
		rd(SMPA_OFF_MGMT_PIN); chk("mgmt pin ctrl", SMPA_RST_PIN_CTRL, rd_v);
		chk("mgmt line idle", 8'h01, {7'h0, m_line});
		rd(SMPA_OFF_WAKE_PIN); chk("wake pin ctrl", SMPA_RST_PIN_CTRL, rd_v);
		rd(8'h7f); chk("unmapped read", 8'h00, rd_v);
		$display("reset test done");
		wr(SMPA_OFF_MGMT_EN1, 8'h01); unit_events[0] = 1; tick(1);
		chk("group irq", 8'h01, {7'h0, irq});
		chk("pin gated", 8'h01, {7'h0, m_line});
		wr(SMPA_OFF_MGMT_EN2, 8'h80); chk("pin low", 8'h00, {7'h0, m_line});
		wr(SMPA_OFF_MGMT_PIN, 8'h81); chk("pin pp high", 8'h03, {6'h0, m_oe, m_o});
		wr(SMPA_OFF_MGMT_EN2, 8'h40); chk("irq2 slot", 8'h01, {7'h0, ser});
		chk("pin idle", 8'h02, {6'h0, m_oe, m_o});
		wr(SMPA_OFF_MGMT_EN2, 8'h00);
		wr(SMPA_OFF_MGMT_STS1, 8'hff); rd(SMPA_OFF_MGMT_STS1);
		chk("unit status", 8'h01, rd_v);
		unit_events[0] = 0; tick(1); chk("unit direct", 8'h00, {7'h0, irq});
		ir_evt = 1; tick(1); ir_evt = 0;
		rd(SMPA_OFF_MGMT_STS2); chk("ir set", 8'h40, rd_v & 8'h40);
		rd(SMPA_OFF_MGMT_STS2); chk("ir read-clear", 8'h00, rd_v & 8'h40);
		$display("routing test done");
		wr(SMPA_OFF_EDGE_CFG, 8'h02); wr(SMPA_OFF_EITHER_EDGE_TRIGGER_CFG, 8'h04);
		gpio_tach_in = 8'h07; tick(2);
		rd(SMPA_OFF_MGMT_STS3); chk("rise edges", 8'h05, rd_v);
		wr(SMPA_OFF_MGMT_STS3, 8'h05); gpio_tach_in = 8'h00; tick(2);
		rd(SMPA_OFF_MGMT_STS3); chk("fall edges", 8'h06, rd_v);
		wr(SMPA_OFF_MGMT_STS3, 8'h00); rd(SMPA_OFF_MGMT_STS3);
		chk("write zero", 8'h06, rd_v);
		wr(SMPA_OFF_MGMT_EN3, 8'h02); chk("latched irq", 8'h01, {7'h0, irq});
		wr(SMPA_OFF_MGMT_STS3, 8'h02); chk("irq cleared", 8'h00, {7'h0, irq});
		rd(SMPA_OFF_WAKE_STS4); chk("gpio wake", 8'h07, rd_v);
		wr(SMPA_OFF_WAKE_STS4, 8'h07); rd(SMPA_OFF_WAKE_STS4);
		chk("gpio wake clr", 8'h00, rd_v);
		wr(SMPA_OFF_MGMT_EN3, 8'h00);
		$display("edge test done");
		unit_events[0] = 1; wr(SMPA_OFF_MGMT_EN2, 8'h20); wr(SMPA_OFF_WAKE_EN3, 8'h08);
		rd(SMPA_OFF_WAKE_STS3); chk("routed sts", 8'h08, rd_v & 8'h08);
		chk("wake blocked", 8'h01, {7'h0, w_line});
		wr(SMPA_OFF_WAKE_STS, 8'h02); chk("wake active", 8'h00, {7'h0, w_line});
		wr(SMPA_OFF_WAKE_PIN, 8'h81); chk("wake pp high", 8'h03, {6'h0, w_oe, w_o});
		wr(SMPA_OFF_WAKE_PIN, 8'h00);
		rd(SMPA_OFF_WAKE_STS); chk("summary set", 8'h01, rd_v & 8'h01);
		unit_events[0] = 0; wr(SMPA_OFF_WAKE_STS3, 8'h08);
		rd(SMPA_OFF_WAKE_STS); chk("summary clr", 8'h00, rd_v & 8'h01);
		chk("wake released", 8'h01, {7'h0, w_line});
		wr(SMPA_OFF_WAKE_STS, 8'h00);
		for (int i = 0; i < 5; i++) begin
			src[i] = 1; tick(2); src[i] = 0;
			rd(SMPA_OFF_WAKE_STS3);
			chk("wake source", (i < 3) ? 8'h01 << i : 8'h01 << (i + 1), rd_v);
			wr(SMPA_OFF_WAKE_STS3, rd_v);
		end
		$display("wake test done");
		wr(SMPA_OFF_LAMP_ONE, {6'h0, SMPA_LAMP_ON}); rd(SMPA_OFF_LAMP_ONE);
		chk("lamp reg", 8'h02, rd_v);
		tick(6000);
		chk("lamp lit", 8'h02, {6'h0, l1_oe, l1_o});
		chk("lamp two off", 8'h00, {6'h0, l2_oe, l2_o});
		wr(SMPA_OFF_LAMP_ONE, {6'h0, SMPA_LAMP_OFF}); wr(SMPA_OFF_LAMP_TWO, 8'h82); tick(6000);
		chk("lamp dark", 8'h00, {6'h0, l1_oe, l1_o});
		chk("lamp two pp", 8'h03, {6'h0, l2_oe, l2_o});
		$display("lamp test done");
		give_verdict;
	end
endmodule : smpa_event_agg_tb
